// >>> ond_detector.sv
// Over-limit and neutral mismatch detector: sample sequencing, register
// port, sticky status flags and the two active-low interrupt lines.
// Assumes samples on the inputs are held steady by the sample source
// and that the register port is driven synchronously to core_clk_in.
`timescale 1ns/100ps
`include "ond_map.svh"

module ond_detector
#(
    parameter int SAMPLE_PERIOD_CYC = `OND_SAMPLE_PERIOD_NS / `OND_CLK_PERIOD_NS
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire ond_pkg::ond_sample_t phase_a_voltage_sample_in,
    input wire ond_pkg::ond_sample_t phase_b_voltage_sample_in,
    input wire ond_pkg::ond_sample_t phase_c_voltage_sample_in,
    input wire ond_pkg::ond_sample_t phase_a_current_sample_in,
    input wire ond_pkg::ond_sample_t phase_b_current_sample_in,
    input wire ond_pkg::ond_sample_t phase_c_current_sample_in,
    input wire ond_pkg::ond_sample_t neutral_current_sample_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_rdata_valid_out,
    output logic interrupt_line_zero_n_out,
    output logic interrupt_line_one_n_out,
    output ond_pkg::ond_wide_t neutral_rms_source_out,
    output logic sample_done_out
);
    import ond_pkg::*;

    localparam int PERIOD_W = $clog2(SAMPLE_PERIOD_CYC + 1);

    ond_state_t state_q;
    logic [PERIOD_W-1:0] tick_cnt_q;
    logic tick;

    logic [23:0] volt_thr_q;
    logic [23:0] curr_thr_q;
    logic [23:0] sum_thr_q;
    logic [31:0] mask_zero_q;
    logic [31:0] mask_one_q;
    logic neutral_sel_q;

    ond_sample_t volt_smp [3];
    ond_sample_t curr_smp [3];
    ond_sample_t curr_cap_q [3];
    ond_sample_t neutral_cap_q;
    ond_wide_t phase_current_sum_q;
    ond_wide_t neutral_rms_src_q;

    logic [2:0] ov_hit;
    logic [2:0] oi_hit;
    logic ov_flag_q;
    logic oi_flag_q;
    logic mis_flag_q;
    logic done_flag_q;
    logic [2:0] ov_phase_q;
    logic [2:0] oi_phase_q;
    logic mis_set;
    logic done_set;

    logic wr_status_one;
    logic wr_status_zero;
    logic [31:0] status_one_view;
    logic [31:0] status_zero_view;
    logic [31:0] phase_status_view;
    logic [31:0] rdata_q;
    logic rvalid_q;

    ond_wide_t phase_current_sum_mag;
    ond_wide_t neutral_mag;
    ond_wide_t mag_diff;
    ond_wide_t sum_thr_ext;

    assign volt_smp[0] = phase_a_voltage_sample_in;
    assign volt_smp[1] = phase_b_voltage_sample_in;
    assign volt_smp[2] = phase_c_voltage_sample_in;
    assign curr_smp[0] = phase_a_current_sample_in;
    assign curr_smp[1] = phase_b_current_sample_in;
    assign curr_smp[2] = phase_c_current_sample_in;

    // Sample-rate tick; shorten the period in simulation via the parameter
    assign tick = (tick_cnt_q == PERIOD_W'(SAMPLE_PERIOD_CYC - 1));

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tick_cnt_q <= '0;
        else if (tick)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_q + PERIOD_W'(1);
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_q <= OND_IDLE;
        else
        begin
            case (state_q)
                OND_IDLE:
                    if (tick)
                        state_q <= OND_CAPTURE;
                OND_CAPTURE:
                    state_q <= OND_SUM;
                OND_SUM:
                    state_q <= OND_COMPARE;
                OND_COMPARE:
                    state_q <= OND_IDLE;
                default:
                    state_q <= OND_IDLE;
            endcase
        end
    end

    // Latch current and neutral samples with the tick
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < 3; i++)
                curr_cap_q[i] <= '0;
            neutral_cap_q <= '0;
        end
        else if (state_q == OND_IDLE && tick)
        begin
            for (int i = 0; i < 3; i++)
                curr_cap_q[i] <= curr_smp[i];
            neutral_cap_q <= neutral_current_sample_in;
        end
    end

    // Per-phase comparators; results valid in the capture state
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_phase
            ond_mag_cmp u_volt_cmp
            (
                .core_clk_in(core_clk_in),
                .rst_n_in(rst_n_in),
                .sample_en_in(state_q == OND_IDLE && tick),
                .sample_in(volt_smp[g]),
                .threshold_in(volt_thr_q),
                .over_out(ov_hit[g])
            );
            ond_mag_cmp u_curr_cmp
            (
                .core_clk_in(core_clk_in),
                .rst_n_in(rst_n_in),
                .sample_en_in(state_q == OND_IDLE && tick),
                .sample_in(curr_smp[g]),
                .threshold_in(curr_thr_q),
                .over_out(oi_hit[g])
            );
        end
    endgenerate

    // 28-bit signed sum of phase currents
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase_current_sum_q <= '0;
        else if (state_q == OND_CAPTURE)
            phase_current_sum_q <= 28'(curr_cap_q[0]) + 28'(curr_cap_q[1]) + 28'(curr_cap_q[2]);
    end

    // Magnitudes of sum and neutral; 28 bits avoid overflow
    assign phase_current_sum_mag = phase_current_sum_q[27] ? (-phase_current_sum_q) : phase_current_sum_q;
    assign neutral_mag = neutral_cap_q[23] ? (-28'(neutral_cap_q)) : 28'(neutral_cap_q);
    assign mag_diff = (phase_current_sum_mag > neutral_mag) ? (phase_current_sum_mag - neutral_mag)
                                               : (neutral_mag - phase_current_sum_mag);
    assign sum_thr_ext = 28'(signed'(sum_thr_q));

    // zero or negative threshold always trips
    assign mis_set = (state_q == OND_COMPARE) &&
                     ((sum_thr_ext <= 28'sh0000000) || (mag_diff > sum_thr_ext));
    // done once the fresh sum is stored
    assign done_set = (state_q == OND_SUM);

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            neutral_rms_src_q <= '0;
        else if (state_q == OND_SUM)
            neutral_rms_src_q <= neutral_sel_q ? phase_current_sum_q : 28'(neutral_cap_q);
    end

    assign wr_status_one = reg_wr_en_in && (reg_addr_in == `OND_OFS_STATUS_ONE);
    assign wr_status_zero = reg_wr_en_in && (reg_addr_in == `OND_OFS_STATUS_ZERO);

    // overvoltage flag and phase bits, set wins over clear
    // write one clears flag and all phase bits
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ov_flag_q <= 1'b0;
            ov_phase_q <= 3'h0;
        end
        else
        begin
            if (wr_status_one && reg_wdata_in[`OND_BIT_OVERVOLTAGE])
            begin
                ov_flag_q <= |ov_hit;
                ov_phase_q <= ov_hit;
            end
            else
            begin
                ov_flag_q <= ov_flag_q | (|ov_hit);
                ov_phase_q <= ov_phase_q | ov_hit;
            end
        end
    end

    // write one clears flag and all phase bits
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            oi_flag_q <= 1'b0;
            oi_phase_q <= 3'h0;
        end
        else
        begin
            if (wr_status_one && reg_wdata_in[`OND_BIT_OVERCURRENT])
            begin
                oi_flag_q <= |oi_hit;
                oi_phase_q <= oi_hit;
            end
            else
            begin
                oi_flag_q <= oi_flag_q | (|oi_hit);
                oi_phase_q <= oi_phase_q | oi_hit;
            end
        end
    end

    // mismatch flag, write one clears, set wins
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            mis_flag_q <= 1'b0;
        else
            mis_flag_q <= (mis_flag_q &
                           ~(wr_status_one && reg_wdata_in[`OND_BIT_MISMATCH])) | mis_set;
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            done_flag_q <= 1'b0;
        else
            done_flag_q <= (done_flag_q &
                            ~(wr_status_zero && reg_wdata_in[`OND_BIT_DONE])) | done_set;
    end

    // Configuration and threshold writes
    // mismatch threshold resets to zero
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            volt_thr_q <= `OND_RST_OVERLIMIT_THR;
            curr_thr_q <= `OND_RST_OVERLIMIT_THR;
            sum_thr_q <= `OND_RST_SUM_THR;
            mask_zero_q <= 32'h00000000;
            mask_one_q <= 32'h00000000;
            neutral_sel_q <= 1'b0;
        end
        else if (reg_wr_en_in)
        begin
            case (reg_addr_in)
                `OND_OFS_VOLT_THR: volt_thr_q <= reg_wdata_in[23:0];
                `OND_OFS_CURR_THR: curr_thr_q <= reg_wdata_in[23:0];
                `OND_OFS_SUM_THR: sum_thr_q <= reg_wdata_in[23:0];
                `OND_OFS_MASK_ZERO: mask_zero_q <= reg_wdata_in;
                `OND_OFS_MASK_ONE: mask_one_q <= reg_wdata_in;
                `OND_OFS_CONFIG_THREE: neutral_sel_q <= reg_wdata_in[`OND_BIT_NEUTRAL_SEL];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        status_one_view = 32'h00000000;
        status_one_view[`OND_BIT_OVERVOLTAGE] = ov_flag_q;
        status_one_view[`OND_BIT_OVERCURRENT] = oi_flag_q;
        status_one_view[`OND_BIT_MISMATCH] = mis_flag_q;
        status_zero_view = 32'h00000000;
        status_zero_view[`OND_BIT_DONE] = done_flag_q;
        phase_status_view = 32'h00000000;
        phase_status_view[`OND_LSB_OV_PHASE +: 3] = ov_phase_q;
        phase_status_view[`OND_LSB_OI_PHASE +: 3] = oi_phase_q;
    end

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd_en_in;
            if (reg_rd_en_in)
            begin
                case (reg_addr_in)
                    `OND_OFS_VOLT_THR: rdata_q <= {8'h00, volt_thr_q};
                    `OND_OFS_CURR_THR: rdata_q <= {8'h00, curr_thr_q};
                    `OND_OFS_PHASE_CURRENT_SUM: rdata_q <= {4'h0, phase_current_sum_q};
                    `OND_OFS_SUM_THR: rdata_q <= {4'h0, sum_thr_ext};
                    `OND_OFS_STATUS_ZERO: rdata_q <= status_zero_view;
                    `OND_OFS_STATUS_ONE: rdata_q <= status_one_view;
                    `OND_OFS_PHASE_STATUS: rdata_q <= phase_status_view;
                    `OND_OFS_MASK_ZERO: rdata_q <= mask_zero_q;
                    `OND_OFS_MASK_ONE: rdata_q <= mask_one_q;
                    `OND_OFS_CONFIG_THREE: rdata_q <= 32'({neutral_sel_q, 2'b00});
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // line follows masked flags in the same cycle
    // overcurrent gated by its mask bit
    // mismatch gated by its mask bit
    assign interrupt_line_one_n_out = ~(|(status_one_view & mask_one_q));
    assign interrupt_line_zero_n_out = ~(|(status_zero_view & mask_zero_q));

    assign reg_rdata_out = rdata_q;
    assign reg_rdata_valid_out = rvalid_q;
    assign neutral_rms_source_out = neutral_rms_src_q;
    assign sample_done_out = done_flag_q;

endmodule // ond_detector

// >>> ond_detector_assertions.sv
// Checker on the detector's register port, interrupt lines and sample timing.
// Assumes binding onto ond_detector; a local counter mirrors the sample tick.
`timescale 1ns/100ps
`include "ond_map.svh"

module ond_detector_assertions
#(
    parameter int SAMPLE_PERIOD_CYC = 16
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic reg_rdata_valid_out,
    input wire logic interrupt_line_zero_n_out,
    input wire logic interrupt_line_one_n_out,
    input wire ond_pkg::ond_wide_t neutral_rms_source_out,
    input wire logic sample_done_out
);
    import ond_pkg::*;
    logic [15:0] phase_q;
    logic [15:0] rd_addr_q;
    logic mask_wr_q;

    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Tick mirror; windows below allow slack after the expected cycle, none before
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            phase_q <= 16'h0000;
        else if (phase_q == 16'(SAMPLE_PERIOD_CYC - 1))
            phase_q <= 16'h0000;
        else
            phase_q <= phase_q + 16'h0001;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reg_rd_en_in)
            rd_addr_q <= reg_addr_in;
    end

    always_ff @(posedge core_clk_in)
    begin
        mask_wr_q <= reg_wr_en_in && reg_addr_in == `OND_OFS_MASK_ONE;
    end

    sequence clear_all_s;
        reg_wr_en_in && reg_addr_in == `OND_OFS_STATUS_ONE && reg_wdata_in[20]
            && (&reg_wdata_in[18:17]) && phase_q inside {[3:14]};
    endsequence

    sequence answered_s(logic [15:0] ofs);
        reg_rdata_valid_out && rd_addr_q == ofs;
    endsequence

    read_answer_a:
        assert property (reg_rd_en_in |=> reg_rdata_valid_out)
        else $error("read strobe not answered next cycle");
    rdata_hold_a:
        assert property ($changed(reg_rdata_out) |-> reg_rdata_valid_out)
        else $error("read data changed without a read");
    thr_top_byte_a:
        assert property (answered_s(`OND_OFS_VOLT_THR) or answered_s(`OND_OFS_CURR_THR)
            |-> reg_rdata_out[31:24] == 8'h00)
        else $error("threshold upper byte not zero");
    phase_current_sum_top_nibble_a:
        assert property (answered_s(`OND_OFS_PHASE_CURRENT_SUM) |-> reg_rdata_out[31:28] == 4'h0)
        else $error("current sum top nibble not zero");
    sum_thr_sext_a:
        assert property (answered_s(`OND_OFS_SUM_THR)
            |-> reg_rdata_out[31:24] == {4'h0, {4{reg_rdata_out[23]}}})
        else $error("mismatch threshold not sign extended");
    irq_cause_a:
        assert property ($fell(interrupt_line_one_n_out) |-> phase_q inside {[1:5]} || mask_wr_q)
        else $error("interrupt line one fell without cause");
    clear_release_a:
        assert property (clear_all_s |=> interrupt_line_one_n_out [*2])
        else $error("interrupt line one not released by clear");
    done_timing_a:
        assert property ($rose(sample_done_out) |-> phase_q inside {[2:4]})
        else $error("done flag rose away from the sample pass");
    zero_line_a:
        assert property (!interrupt_line_zero_n_out |-> sample_done_out)
        else $error("interrupt line zero low without done flag");
    rms_update_a:
        assert property ($changed(neutral_rms_source_out) |-> phase_q inside {[2:4]})
        else $error("neutral rms source changed away from the sample pass");
endmodule // ond_detector_assertions

bind ond_detector ond_detector_assertions #(.SAMPLE_PERIOD_CYC(SAMPLE_PERIOD_CYC)) u_ond_chk (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .reg_wr_en_in(reg_wr_en_in),
    .reg_rd_en_in(reg_rd_en_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rdata_valid_out(reg_rdata_valid_out),
    .interrupt_line_zero_n_out(interrupt_line_zero_n_out),
    .interrupt_line_one_n_out(interrupt_line_one_n_out),
    .neutral_rms_source_out(neutral_rms_source_out),
    .sample_done_out(sample_done_out)
);

// >>> ond_host_model.sv
// Host controller model driving the detector's register port.
// Assumes tasks are entered 1 ns after a rising edge of core_clk_in.
`timescale 1ns/100ps
`include "ond_map.svh"

module ond_host_model
(
    input wire logic core_clk_in,
    output logic reg_wr_en_out,
    output logic reg_rd_en_out,
    output logic [15:0] reg_addr_out,
    output logic [31:0] reg_wdata_out,
    input wire logic [31:0] reg_rdata_in,
    input wire logic reg_rdata_valid_in
);
    initial
    begin
        reg_wr_en_out = 1'b0;
        reg_rd_en_out = 1'b0;
        reg_addr_out = 16'h0000;
        reg_wdata_out = 32'h0000_0000;
    end

    // Idle bus toggles so a stale address never looks valid
    task automatic end_cycle();
        reg_addr_out = ~reg_addr_out;
        reg_wdata_out = ~reg_wdata_out;
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic write_reg(input logic [15:0] addr, input logic [31:0] data);
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_wr_en_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        reg_wr_en_out = 1'b0;
        end_cycle();
    endtask

    // Data stays unknown if no answer comes within the bound
    task automatic read_reg(input logic [15:0] addr, output logic [31:0] data);
        int n;
        data = 'x;
        reg_addr_out = addr;
        reg_rd_en_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        reg_rd_en_out = 1'b0;
        for (n = 0; n < 4; n++)
        begin
            if (reg_rdata_valid_in === 1'b1)
            begin
                data = reg_rdata_in;
                break;
            end
            @(posedge core_clk_in);
            #1;
        end
        end_cycle();
    endtask

    task automatic init_threshold(input logic [31:0] thr);
        write_reg(`OND_OFS_SUM_THR, thr);
    endtask

    task automatic service(input int bit_no, output logic [31:0] st, output logic [31:0] ph);
        read_reg(`OND_OFS_STATUS_ONE, st);
        read_reg(`OND_OFS_PHASE_STATUS, ph);
        write_reg(`OND_OFS_STATUS_ONE, 32'h0000_0001 << bit_no);
    endtask
endmodule // ond_host_model

// >>> ond_mag_cmp.sv
// One magnitude-versus-threshold comparator for a single phase sample.
// Assumes the caller pulses sample_en_in once per captured sample set.
`timescale 1ns/100ps
`include "ond_map.svh"

module ond_mag_cmp
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sample_en_in,
    input wire ond_pkg::ond_sample_t sample_in,
    input wire logic [23:0] threshold_in,
    output logic over_out
);
    import ond_pkg::*;

    logic [23:0] mag;
    logic over_q;
    logic over_d;

    // Full-scale negative magnitude still fits the unsigned 24 bits
    assign mag = sample_in[23] ? 24'((~sample_in) + 24'sh000001) : 24'(sample_in);

    always_comb
    begin
        if (threshold_in == 24'h000000)
            over_d = 1'b1;
        else if (threshold_in >= `OND_MAX_MAGNITUDE)
            over_d = 1'b0;
        else
            over_d = (mag > threshold_in);
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            over_q <= 1'b0;
        else if (sample_en_in)
            over_q <= over_d;
        else
            over_q <= 1'b0;
    end

    assign over_out = over_q;

endmodule // ond_mag_cmp

// >>> ond_map.svh
// Register offsets, field positions, reset values and timing periods in ns
// for the over-limit and neutral mismatch detector.
// Included by the design modules and the testbench; definitions only.
`ifndef OND_MAP_SVH
`define OND_MAP_SVH

// Byte offsets on the register port
`define OND_OFS_VOLT_THR 16'h0000
`define OND_OFS_CURR_THR 16'h0004
`define OND_OFS_PHASE_CURRENT_SUM 16'h0008
`define OND_OFS_SUM_THR 16'h000c
`define OND_OFS_STATUS_ZERO 16'h0010
`define OND_OFS_STATUS_ONE 16'h0014
`define OND_OFS_PHASE_STATUS 16'h0018
`define OND_OFS_MASK_ZERO 16'h001c
`define OND_OFS_MASK_ONE 16'h0020
`define OND_OFS_CONFIG_THREE 16'h0024

// Field positions
`define OND_BIT_DONE 17
`define OND_BIT_OVERCURRENT 17
`define OND_BIT_OVERVOLTAGE 18
`define OND_BIT_MISMATCH 20
`define OND_LSB_OV_PHASE 9
`define OND_LSB_OI_PHASE 3
`define OND_BIT_NEUTRAL_SEL 2

// Reset values and magnitude limit
`define OND_RST_OVERLIMIT_THR 24'h514791
`define OND_RST_SUM_THR 24'h000000
`define OND_MAX_MAGNITUDE 24'h514791

// Sample period and core clock period, in ns
`define OND_SAMPLE_PERIOD_NS 125000
`define OND_CLK_PERIOD_NS 8

`endif

// >>> ond_pkg.sv
// Types shared by the detector modules.
// Assumes ond_map.svh supplies the numeric constants.
package ond_pkg;

    // Gray coded along idle, capture, sum, compare
    typedef enum logic [1:0] {
        OND_IDLE = 2'b00,
        OND_CAPTURE = 2'b01,
        OND_SUM = 2'b11,
        OND_COMPARE = 2'b10
    } ond_state_t;

    typedef logic signed [23:0] ond_sample_t;
    typedef logic signed [27:0] ond_wide_t;

endpackage

// >>> testbench.sv
// Self-checking bench for the over-limit and mismatch detector.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "ond_map.svh"

module testbench;
    import ond_pkg::*;
    localparam int PERIOD = 16;
    localparam logic [15:0] A_S1 = `OND_OFS_STATUS_ONE;
    localparam logic [15:0] A_PH = `OND_OFS_PHASE_STATUS;
    logic core_clk_in;
    logic rst_n_in;
    ond_sample_t va, vb, vc, ia, ib, ic, inn;
    logic wr_en, rd_en, valid, irq0_n, interrupt_line_one_n_n, done;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, st, ph, got;
    ond_wide_t rms_src;
    int fail_count = 0;
    int checked = 0;

    ond_detector #(.SAMPLE_PERIOD_CYC(PERIOD)) dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .phase_a_voltage_sample_in(va), .phase_b_voltage_sample_in(vb),
        .phase_c_voltage_sample_in(vc), .phase_a_current_sample_in(ia),
        .phase_b_current_sample_in(ib), .phase_c_current_sample_in(ic),
        .neutral_current_sample_in(inn), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rdata_valid_out(valid), .interrupt_line_zero_n_out(irq0_n),
        .interrupt_line_one_n_out(interrupt_line_one_n_n), .neutral_rms_source_out(rms_src),
        .sample_done_out(done));

    ond_host_model host (
        .core_clk_in(core_clk_in), .reg_wr_en_out(wr_en), .reg_rd_en_out(rd_en),
        .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
        .reg_rdata_valid_in(valid));

    initial
    begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        checked++;
        if (got_v !== exp_v)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        host.read_reg(a, got);
        check(got, e);
    endtask

    // Waits for the done flag; returns in the compare cycle of the pass
    task automatic wait_done();
        int n;
        for (n = 0; n < 2 * PERIOD && !done; n++)
        begin
            @(posedge core_clk_in);
            #1;
        end
        check({31'h0, done}, 32'h1);
    endtask

    task automatic periods(input int n);
        repeat (n * PERIOD) @(posedge core_clk_in);
        #1;
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        rst_n_in = 1'b0;
        {va, vb, vc, ia, ib, ic, inn} = '0;
        repeat (10) @(posedge core_clk_in);
        #1;
        rst_n_in = 1'b1;
        rd_chk(`OND_OFS_VOLT_THR, 32'h0051_4791);
        rd_chk(`OND_OFS_CURR_THR, 32'h0051_4791);
        rd_chk(`OND_OFS_SUM_THR, 32'h0000_0000);
        rd_chk(16'h0030, 32'h0000_0000);
        host.write_reg(`OND_OFS_MASK_ONE, 32'h0016_0000);
        host.write_reg(`OND_OFS_MASK_ZERO, 32'h0002_0000);
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h0);
        rd_chk(A_S1, 32'h0010_0000);
        rd_chk(`OND_OFS_STATUS_ZERO, 32'h0002_0000);
        check({30'h0, irq0_n, done}, 32'h1);
        host.write_reg(`OND_OFS_SUM_THR, 32'h0080_0000);
        rd_chk(`OND_OFS_SUM_THR, 32'h0f80_0000);
        host.init_threshold(32'h0000_0100);
        periods(1);
        host.write_reg(A_S1, 32'h0010_0000);
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h1);
        // Overvoltage on A and C; B equal to threshold stays quiet
        host.write_reg(`OND_OFS_VOLT_THR, 32'hff00_1000);
        rd_chk(`OND_OFS_VOLT_THR, 32'h0000_1000);
        va = 24'sh002000;
        vb = 24'sh001000;
        vc = -24'sh002000;
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h0);
        {va, vc} = '0;
        host.service(`OND_BIT_OVERVOLTAGE, st, ph);
        check(st & 32'h0016_0000, 32'h0004_0000);
        check(ph, 32'h0000_0a00);
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h1);
        rd_chk(A_PH, 32'h0000_0000);
        // Overcurrent on B; neutral balances the sum
        host.write_reg(`OND_OFS_CURR_THR, 32'h0000_1000);
        ib = -24'sh001001;
        inn = 24'sh001001;
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h0);
        host.write_reg(`OND_OFS_PHASE_CURRENT_SUM, 32'h0000_0000);
        rd_chk(`OND_OFS_PHASE_CURRENT_SUM, 32'h0fff_efff);
        {ib, inn} = '0;
        host.service(`OND_BIT_OVERCURRENT, st, ph);
        check(st & 32'h0016_0000, 32'h0002_0000);
        check(ph, 32'h0000_0010);
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h1);
        rd_chk(A_PH, 32'h0000_0000);
        // Full-scale threshold with large currents; sum disagrees with neutral
        host.write_reg(`OND_OFS_CURR_THR, 32'h0051_4791);
        {ia, ib, ic} = {3{24'sh600000}};
        inn = 24'sh100000;
        host.write_reg(`OND_OFS_CONFIG_THREE, 32'h0000_0004);
        periods(2);
        check({4'h0, rms_src}, 32'h0120_0000);
        rd_chk(A_S1, 32'h0010_0000);
        check({31'h0, interrupt_line_one_n_n}, 32'h0);
        host.write_reg(`OND_OFS_CONFIG_THREE, 32'h0000_0000);
        periods(2);
        check({4'h0, rms_src}, 32'h0010_0000);
        {ia, ib, ic, inn} = '0;
        periods(1);
        host.write_reg(A_S1, 32'h0010_0000);
        periods(2);
        check({31'h0, interrupt_line_one_n_n}, 32'h1);
        // Zero threshold keeps every phase flagged after a clear
        host.write_reg(`OND_OFS_CURR_THR, 32'h0000_0000);
        periods(2);
        host.write_reg(A_S1, 32'h0002_0000);
        periods(2);
        rd_chk(A_S1, 32'h0002_0000);
        rd_chk(A_PH, 32'h0000_0038);
        check({31'h0, interrupt_line_one_n_n}, 32'h0);
        // Second clear only if a set landed on the first
        host.write_reg(`OND_OFS_STATUS_ZERO, 32'h0002_0000);
        if (done)
            host.write_reg(`OND_OFS_STATUS_ZERO, 32'h0002_0000);
        check({31'h0, done}, 32'h0);
        wait_done();
        // Clear all status-one flags between passes; line high until the next pass
        host.write_reg(A_S1, 32'h0016_0000);
        check({31'h0, interrupt_line_one_n_n}, 32'h1);
        rd_chk(A_PH, 32'h0000_0000);
        periods(1);
        check({31'h0, interrupt_line_one_n_n}, 32'h0);
        summarize();
    end
endmodule // testbench
